// ==== core/emb_memory_block.sv ====
/*
 * Embedded memory block: 2048 bits with selectable word shape, optional
 * pipeline registers and separate input and output clock events.
 * Assumes the surrounding logic drives all inputs synchronous to clock_in
 * and widens or deepens memories by instancing several blocks.
 */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module emb_memory_block (
  input  wire logic                       clock_in,
  input  wire logic                       sys_rst_in,
  // Register port
  input  wire logic [emb_pkg::REG_AW-1:0] reg_addr_in,
  input  wire logic [31:0]                reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic      [31:0]                reg_rdata_out,
  // User memory port
  input  wire logic [emb_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [emb_pkg::DATA_W-1:0] din_in,
  input  wire logic                       wen_global_in,
  input  wire logic                       wen_local_in,
  input  wire logic                       block_sel_in,
  input  wire logic                       in_clk_pin_in,
  input  wire logic                       in_clk_local_in,
  input  wire logic                       out_clk_pin_in,
  input  wire logic                       out_clk_local_in,
  output logic      [emb_pkg::DATA_W-1:0] dout_out,
  output logic                            dout_sel_out
);

  // ****************************************
  // Address decoding helpers
  // ****************************************
  function automatic logic [emb_pkg::ADDR_W-1:0] bit_index(
    input logic [emb_pkg::ADDR_W-1:0] addr,
    input logic [1:0]                 shape,
    input int unsigned                lane
  );
    logic [emb_pkg::ADDR_W-1:0] mask;
    logic [1:0]                 shift;
    logic [emb_pkg::ADDR_W-1:0] lane_b;
    mask   = emb_pkg::ADDR_W'((1 << (emb_pkg::BASE_ABITS + int'(shape))) - 1);
    shift  = emb_pkg::SHIFT_MAX - shape;
    lane_b = emb_pkg::ADDR_W'(lane);
    bit_index = emb_pkg::ADDR_W'((addr & mask) << shift) | lane_b;
  endfunction : bit_index

  function automatic logic lane_used(input logic [1:0] shape, input int unsigned lane);
    lane_used = lane < (emb_pkg::DATA_W >> shape);
  endfunction : lane_used

  // ****************************************
  // State
  // ****************************************
  logic                       mem [0:emb_pkg::BITS_TOTAL-1];
  emb_pkg::emb_cfg_s          cfg_reg;
  logic [emb_pkg::ADDR_W-1:0] load_addr_reg;
  logic [emb_pkg::DATA_W-1:0] din_reg;
  emb_pkg::emb_port_s         port_reg;
  logic                       sel_reg;
  logic [emb_pkg::DATA_W-1:0] rd_reg;
  logic                       rd_sel_reg;
  logic [emb_pkg::DATA_W-1:0] dout_reg;
  logic                       dout_sel_reg;
  logic [31:0]                rdata_reg;

  logic                       in_tick;
  logic                       out_tick;
  logic [emb_pkg::DATA_W-1:0] eff_din;
  emb_pkg::emb_port_s         eff_port;
  emb_pkg::emb_port_s         raw_port;
  logic                       eff_sel;
  logic                       wr_strobe;
  logic                       load_strobe;
  logic [emb_pkg::DATA_W-1:0] word_now;
  logic [emb_pkg::DATA_W-1:0] word_load;

  // ****************************************
  // Clock event selection
  // ****************************************
  emb_clk_tick u_in_tick (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .src_in       (cfg_reg.in_clk_src),
    .pin_clk_in   (in_clk_pin_in),
    .local_clk_in (in_clk_local_in),
    .tick_out     (in_tick)
  );

  // Output side has its own source, so reads can be paced apart from writes
  emb_clk_tick u_out_tick (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .src_in       (cfg_reg.out_clk_src),
    .pin_clk_in   (out_clk_pin_in),
    .local_clk_in (out_clk_local_in),
    .tick_out     (out_tick)
  );

  // ****************************************
  // Input path selection
  // ****************************************
  always_comb begin
    raw_port.wen  = cfg_reg.wen_local ? wen_local_in : wen_global_in;
    raw_port.addr = addr_in;
    eff_din  = cfg_reg.reg_din  ? din_reg  : din_in;
    eff_port = cfg_reg.reg_addr ? port_reg : raw_port;
    eff_sel  = cfg_reg.reg_addr ? sel_reg  : block_sel_in;
    // Strobe made inside; user logic only meets the clock edge
    wr_strobe   = in_tick & eff_port.wen & eff_sel & ~cfg_reg.rom_mode;
    load_strobe = reg_wr_in & (reg_addr_in == emb_pkg::OFF_LOAD_DAT);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      din_reg <= '0;
    end else if (in_tick) begin
      din_reg <= din_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      port_reg <= '0;
      sel_reg  <= 1'b0;
    end else if (in_tick) begin
      port_reg <= raw_port;
      sel_reg  <= block_sel_in;
    end
  end

  // ****************************************
  // Storage array and lane shaping
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < emb_pkg::DATA_W; g++) begin : g_lane
      // Unused lanes of narrow shapes read as zero
      assign word_now[g]  = lane_used(cfg_reg.shape, g) &
                            mem[bit_index(eff_port.addr, cfg_reg.shape, g)];
      assign word_load[g] = lane_used(cfg_reg.shape, g) &
                            mem[bit_index(load_addr_reg, cfg_reg.shape, g)];
    end
  endgenerate

  // Contents are not reset; the load port sets the pattern, bus load wins a clash
  always_ff @(posedge clock_in) begin
    for (int i = 0; i < emb_pkg::DATA_W; i++) begin
      if (wr_strobe && lane_used(cfg_reg.shape, i)) begin
        mem[bit_index(eff_port.addr, cfg_reg.shape, i)] <= eff_din[i];
      end
      if (load_strobe && lane_used(cfg_reg.shape, i)) begin
        mem[bit_index(load_addr_reg, cfg_reg.shape, i)] <= reg_wdata_in[i];
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Select travels with its word, so a registered output never pairs stale data
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rd_reg     <= '0;
      rd_sel_reg <= 1'b0;
    end else begin
      rd_reg     <= eff_sel ? word_now : '0;
      rd_sel_reg <= eff_sel;
    end
  end

  // Bypass still costs one flop stage so the output never glitches
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      dout_reg     <= '0;
      dout_sel_reg <= 1'b0;
    end else if (!cfg_reg.reg_dout) begin
      dout_reg     <= eff_sel ? word_now : '0;
      dout_sel_reg <= eff_sel;
    end else if (out_tick) begin
      dout_reg     <= rd_reg;
      dout_sel_reg <= rd_sel_reg;
    end
  end

  // Unselected blocks drive zero, so cascaded outputs combine with a plain OR
  assign dout_out     = dout_reg;
  assign dout_sel_out = dout_sel_reg;

  // ****************************************
  // Register port
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cfg_reg <= emb_pkg::CFG_RESET;
    end else if (reg_wr_in && reg_addr_in == emb_pkg::OFF_CONFIG) begin
      cfg_reg <= emb_pkg::emb_cfg_s'(reg_wdata_in[emb_pkg::CFG_W-1:0]);
    end
  end

  // Load address steps on each data write for a fast pattern download
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      load_addr_reg <= '0;
    end else if (reg_wr_in && reg_addr_in == emb_pkg::OFF_LOAD_ADR) begin
      load_addr_reg <= reg_wdata_in[emb_pkg::ADDR_W-1:0];
    end else if (load_strobe) begin
      load_addr_reg <= load_addr_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rdata_reg <= emb_pkg::RDATA_NONE;
    end else if (!reg_rd_in) begin
      rdata_reg <= emb_pkg::RDATA_NONE;
    end else begin
      unique case (reg_addr_in)
        emb_pkg::OFF_CONFIG:   rdata_reg <= 32'(cfg_reg);
        emb_pkg::OFF_LOAD_ADR: rdata_reg <= 32'(load_addr_reg);
        emb_pkg::OFF_LOAD_DAT: rdata_reg <= 32'(word_load);
        emb_pkg::OFF_STATUS:   rdata_reg <= 32'({dout_sel_reg, dout_reg});
        default:               rdata_reg <= emb_pkg::RDATA_NONE;
      endcase
    end
  end

  assign reg_rdata_out = rdata_reg;

endmodule : emb_memory_block

// ==== core/emb_pkg.sv ====
/*
 * Constants, register map and carrier types for the embedded memory block.
 * Assumes one system clock and a plain register port driven by the surrounding logic.
 */
package emb_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned BITS_TOTAL = 2048;
  localparam int unsigned ADDR_W     = 11;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned MODE_COUNT = 4;
  localparam logic [1:0]  SHIFT_MAX  = 2'h3;
  localparam int unsigned BASE_ABITS = 8;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned  REG_AW       = 4;
  localparam logic [3:0]   OFF_CONFIG   = 4'h0;
  localparam logic [3:0]   OFF_LOAD_ADR = 4'h4;
  localparam logic [3:0]   OFF_LOAD_DAT = 4'h8;
  localparam logic [3:0]   OFF_STATUS   = 4'hC;
  localparam logic [31:0]  RDATA_NONE   = 32'h0000_0000;

  // ****************************************
  // Word shapes and clock sources
  // ****************************************
  typedef enum logic [1:0] {
    EMB_SHAPE_256X8  = 2'h0,
    EMB_SHAPE_512X4  = 2'h1,
    EMB_SHAPE_1024X2 = 2'h2,
    EMB_SHAPE_2048X1 = 2'h3
  } emb_shape_e;

  typedef enum logic [1:0] {
    EMB_CLK_FREE  = 2'h0,
    EMB_CLK_PIN   = 2'h1,
    EMB_CLK_LOCAL = 2'h2
  } emb_clk_src_e;

  typedef struct packed {
    logic [1:0] out_clk_src;
    logic [1:0] in_clk_src;
    logic       wen_local;
    logic       rom_mode;
    logic       reg_dout;
    logic       reg_addr;
    logic       reg_din;
    logic [1:0] shape;
  } emb_cfg_s;

  localparam int unsigned CFG_W     = 11;
  localparam emb_cfg_s    CFG_RESET = 11'h000;

  typedef struct packed {
    logic              wen;
    logic [ADDR_W-1:0] addr;
  } emb_port_s;

endpackage : emb_pkg

// ==== core/emb_clk_tick.sv ====
/*
 * Clock event selector for one side of the memory block.
 * Assumes pin and local clock signals are synchronous to clock_in.
 */
`timescale 1ns/1ps
module emb_clk_tick (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic [1:0] src_in,
  input  wire logic       pin_clk_in,
  input  wire logic       local_clk_in,
  output logic            tick_out
);

  logic picked;
  logic prev_reg;

  // Free source ticks each cycle; others tick on a rising edge
  always_comb begin
    picked = (src_in == emb_pkg::EMB_CLK_PIN) ? pin_clk_in : local_clk_in;
    tick_out = (src_in == emb_pkg::EMB_CLK_FREE) ? 1'b1 : (picked & ~prev_reg);
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= picked;
    end
  end

endmodule : emb_clk_tick

// ==== dv/emb_far_clocks.sv ====
/* Far-side user logic: pin and local clock sources for the memory block.
   Assumes it runs from the same clock_in as the block. */
`timescale 1ns/1ps
module emb_far_clocks (
  input  wire logic clock_in,
  input  wire logic run_in,
  output logic      pin_clk_out,
  output logic      local_clk_out
);
  logic [1:0] div_reg;
  // Stands still at 0 outside a run
  always_ff @(posedge clock_in) begin
    if (!run_in) div_reg <= 2'h0;
    else div_reg <= div_reg + 2'h1;
  end
  assign pin_clk_out   = div_reg[1];
  assign local_clk_out = div_reg[0];
endmodule : emb_far_clocks

// ==== dv/emb_mem_monitor.sv ====
/* Port checker for emb_memory_block.
   Assumes CONFIG changes only by bus writes to offset 0x0. */
`timescale 1ns/1ps
module emb_mem_chk (
  input wire logic        clock_in,
  input wire logic        sys_rst_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        block_sel_in,
  input wire logic [7:0]  dout_out,
  input wire logic        dout_sel_out
);
  logic [10:0] cfg_reg;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) cfg_reg <= 11'h000;
    else if (reg_wr_in && reg_addr_in == 4'h0) cfg_reg <= reg_wdata_in[10:0];
  end
  // Free clocks only: pin or local events stretch the latency
  wire byp = cfg_reg[4:2] == 3'h0 && cfg_reg[10:7] == 4'h0;
  wire rga = cfg_reg[4:2] == 3'h2 && cfg_reg[10:7] == 4'h0;
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero outside read");
  cfg_read_a: assert property (reg_rd_in && reg_addr_in == 4'h0
    |=> reg_rdata_out == {21'h0, $past(cfg_reg)}) else $error("config readback");
  unmap_zero_a: assert property (reg_rd_in && reg_addr_in[1:0] != 2'h0
    |=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
  unsel_zero_a: assert property (!dout_sel_out |-> dout_out == 8'h00)
    else $error("unselected output not zero");
  byp_sel_a: assert property (byp |=> dout_sel_out == $past(block_sel_in))
    else $error("bypass select latency");
  rga_sel_a: assert property (rga ##1 rga |=>
    dout_sel_out == $past(block_sel_in, 2)) else $error("registered address latency");
  stat_read_a: assert property (reg_rd_in && reg_addr_in == 4'hC |=>
    reg_rdata_out == {23'h0, $past(dout_sel_out), $past(dout_out)}) else $error("status");
  rst_clear_a: assert property (disable iff (1'b0) sys_rst_in |=>
    dout_out == 8'h00 && !dout_sel_out && reg_rdata_out == 32'h0) else $error("reset");
endmodule : emb_mem_chk
bind emb_memory_block emb_mem_chk emb_mem_chk_i (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .block_sel_in(block_sel_in),
  .dout_out(dout_out), .dout_sel_out(dout_sel_out));

// ==== dv/tb_top.sv ====
/* Self-checking bench for emb_memory_block.
   Assumes emb_far_clocks as the far side and the checker bound in. */
`timescale 1ns/1ps
module tb_top;
  logic        clock_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [3:0]  reg_addr_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [10:0] addr_in = 11'h000;
  logic [7:0]  din_in = 8'h00;
  logic        we = 1'b0;
  logic        we_loc = 1'b0;
  logic        sel = 1'b1;
  logic        run = 1'b0;
  logic        pin_clk;
  logic        loc_clk;
  logic [7:0]  dout_out;
  logic        dout_sel_out;
  int          fail_count = 0;
  int          cmp_count = 0;

  always #5 clock_in = ~clock_in;

  emb_far_clocks emb_far_clocks_i (.clock_in(clock_in), .run_in(run),
    .pin_clk_out(pin_clk), .local_clk_out(loc_clk));
  emb_memory_block emb_memory_block_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .addr_in(addr_in),
    .din_in(din_in), .wen_global_in(we), .wen_local_in(we_loc), .block_sel_in(sel),
    .in_clk_pin_in(pin_clk), .in_clk_local_in(loc_clk), .out_clk_pin_in(pin_clk),
    .out_clk_local_in(loc_clk), .dout_out(dout_out), .dout_sel_out(dout_sel_out));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
  endtask : rdc

  // Write request held for h cycles so a slow input event still sees it
  // Lw picks the local write request instead of the global one
  task automatic uwr(input logic [10:0] a, input logic [7:0] d, input int h, input logic lw);
    @(posedge clock_in);
    addr_in <= a;
    din_in  <= d;
    we      <= ~lw;
    we_loc  <= lw;
    repeat (h) @(posedge clock_in);
    we     <= 1'b0;
    we_loc <= 1'b0;
  endtask : uwr

  task automatic urd(input logic [10:0] a, input int n, input logic [8:0] exp);
    @(posedge clock_in);
    addr_in <= a;
    repeat (n) @(posedge clock_in);
    #1 chk({23'h0, dout_sel_out, dout_out}, {23'h0, exp});
  endtask : urd

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_regs();
    rdc(4'h0, 32'h0);
    wr(4'h0, 32'h7FF);
    rdc(4'h0, 32'h7FF);
    rdc(4'h2, 32'h0);
  endtask : s_regs

  task automatic s_shapes();
    logic [10:0] top;
    logic [7:0]  m;
    for (int s = 0; s < 4; s++) begin
      top = 11'h7FF >> (3 - s);
      m   = 8'hFF >> (8 - (8 >> s));
      wr(4'h0, 32'(s));
      uwr(top, 8'h5A, 1, 1'b0);
      urd(top, 1, {1'b1, 8'h5A & m});
    end
  endtask : s_shapes

  task automatic s_layout();
    wr(4'h0, 32'h0);
    uwr(11'h000, 8'hA5, 1, 1'b0);
    wr(4'h0, 32'h3);
    for (int i = 0; i < 8; i++) urd(11'(i), 1, {8'h80, 1'(8'hA5 >> i)});
  endtask : s_layout

  task automatic s_rom_sel();
    wr(4'h0, 32'h20);
    wr(4'h4, 32'h010);
    wr(4'h8, 32'h3C);
    wr(4'h8, 32'hC3);
    wr(4'h4, 32'h010);
    rdc(4'h8, 32'h3C);
    uwr(11'h011, 8'hFF, 1, 1'b0);
    urd(11'h011, 1, 9'h1C3);
    wr(4'h0, 32'h0);
    @(posedge clock_in);
    sel <= 1'b0;
    uwr(11'h011, 8'h77, 1, 1'b0);
    urd(11'h011, 1, 9'h000);
    rdc(4'hC, 32'h0);
    @(posedge clock_in);
    sel <= 1'b1;
    urd(11'h011, 1, 9'h1C3);
  endtask : s_rom_sel

  task automatic s_pipe();
    wr(4'h0, 32'h1C);
    uwr(11'h022, 8'h96, 2, 1'b0);
    urd(11'h022, 6, 9'h196);
    wr(4'h0, 32'h10);
    urd(11'h011, 1, 9'h196);
    urd(11'h011, 3, 9'h1C3);
    // Registered address: new address and select show one cycle later
    wr(4'h0, 32'h08);
    urd(11'h022, 1, 9'h1C3);
    urd(11'h022, 1, 9'h196);
    @(posedge clock_in);
    sel <= 1'b0;
    urd(11'h022, 0, 9'h196);
    urd(11'h022, 1, 9'h000);
    @(posedge clock_in);
    sel <= 1'b1;
  endtask : s_pipe

  task automatic s_clk();
    @(posedge clock_in);
    run <= 1'b1;
    // Pin input events, local output events, registered output, local write request
    wr(4'h0, 32'h4D0);
    uwr(11'h033, 8'h69, 5, 1'b1);
    urd(11'h033, 4, 9'h169);
    uwr(11'h033, 8'h96, 5, 1'b0);
    urd(11'h033, 4, 9'h169);
    @(posedge clock_in);
    run <= 1'b0;
  endtask : s_clk

  initial begin
    repeat (16) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    s_regs();
    s_shapes();
    s_layout();
    s_rom_sel();
    s_pipe();
    s_clk();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    final_report();
  end
endmodule : tb_top
